// ### design/fixed_point_simd_saturation.v
// Packed fixed-point datapath with saturation, precision reduce, accumulate and lane order.
// How it works
// RL1: Saturated overflow becomes nearest representable value.
// RL2: Unsigned saturates to zero or lane maximum.
// RL3: Signed saturates to lane minimum or maximum.
// RL4: Fractional minus one squared gives maximum positive.
// RL5: Round-and-saturate rounds up first, then saturates.
// RL6: Accumulate-saturate clamps sum plus product check.
// RL7: Signedness changes only saturation limits, never traps.
// RL8: Add and subtract bits ignore fractional reading.
// RL9: Operands are 32-bit words of packed lanes.
// RL10: Halfword lane results land in matching positions.
// RL11: Two formats: first is output, second input.
// RL12: One format serves sources and destination alike.
// RL13: Big-endian load puts element zero leftmost.
// RL14: Little-endian puts element zero rightmost, all sizes.
// RL15: Lane selection uses left/right, ignoring endianness.
// RL16: Add/subtract overflow sets sticky flag.
// RL17: Flags clear only by explicit software write; the code also clears them on reset.
// RL18: Unsaturated lanes wrap without inter-lane carry.
`timescale 1ns/1ps
`include "fixed_point_simd_defines.vh"

module fixed_point_simd_saturation #(
    parameter DW = 32,
    parameter FW = 8
) (
    input  wire          mclk,
    input  wire          reset,
    input  wire          op_valid,
    input  wire [2:0]    op_code,
    input  wire [1:0]    lane_format,
    input  wire          is_signed,
    input  wire          saturate,
    input  wire          round_and_saturate_modifier,
    input  wire          accumulate_saturate_modifier,
    input  wire          select_left,
    input  wire          little_endian,
    input  wire [4:0]    shift_amount,
    input  wire [DW-1:0] src_a,
    input  wire [DW-1:0] src_b,
    input  wire [DW-1:0] acc_in,
    input  wire          flag_write,
    input  wire [FW-1:0] flag_wdata,
    output reg  [DW-1:0] result_r,
    output reg           result_valid_r,
    output reg  [FW-1:0] ouflag_r
);
    wire [DW-1:0] y_quad;
    wire [DW-1:0] y_pair;
    wire [DW-1:0] y_w;
    wire [3:0]    o_quad;
    wire [1:0]    o_pair;
    wire          o_w;
    wire          sat_any = saturate | round_and_saturate_modifier;
    genvar i;

    // Each width has its own lanes; the format picks which set is read back.
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_quad
            simd_lane #(.W(8)) u_lane (
                .a         (src_a[8*i+7:8*i]),
                .b         (src_b[8*i+7:8*i]),
                .op        (op_code),
                .is_signed (is_signed),
                .sat       (sat_any),
                .rnd       (round_and_saturate_modifier),
                .shamt     (shift_amount),
                .y         (y_quad[8*i+7:8*i]),
                .ovf       (o_quad[i])
            ); // RL9
        end
        for (i = 0; i < 2; i = i + 1) begin : g_pair
            simd_lane #(.W(16)) u_lane (
                .a         (src_a[16*i+15:16*i]),
                .b         (src_b[16*i+15:16*i]),
                .op        (op_code),
                .is_signed (is_signed),
                .sat       (sat_any),
                .rnd       (round_and_saturate_modifier),
                .shamt     (shift_amount),
                .y         (y_pair[16*i+15:16*i]),
                .ovf       (o_pair[i])
            ); // RL10
        end
    endgenerate

    simd_lane #(.W(32)) u_word (
        .a         (src_a),
        .b         (src_b),
        .op        (op_code),
        .is_signed (is_signed),
        .sat       (sat_any),
        .rnd       (round_and_saturate_modifier),
        .shamt     (shift_amount),
        .y         (y_w),
        .ovf       (o_w)
    );

    // Word to halfword precision reduce: rounds on bit 15, then clamps.
    wire [32:0] ra     = {src_a[31], src_a} + (round_and_saturate_modifier ? `HALF_ROUND : 33'h0);
    wire [32:0] rb     = {src_b[31], src_b} + (round_and_saturate_modifier ? `HALF_ROUND : 33'h0);
    wire        ra_ovf = ra[32] ^ ra[31];
    wire        rb_ovf = rb[32] ^ rb[31];
    wire [15:0] ha     = ra_ovf ? `Q15_MAX : ra[31:16]; // RL5
    wire [15:0] hb     = rb_ovf ? `Q15_MAX : rb[31:16]; // RL5

    // Multiply-accumulate on the left or right halfword, named by register position.
    wire [15:0]        ma     = select_left ? src_a[31:16] : src_a[15:0]; // RL15
    wire [15:0]        mb     = select_left ? src_b[31:16] : src_b[15:0]; // RL15
    wire signed [31:0] mprod  = $signed(ma) * $signed(mb);
    wire               m_both = (ma == `Q15_MIN) && (mb == `Q15_MIN);
    wire [31:0]        mq     = m_both ? `Q31_MAX : (mprod <<< 1); // RL6 RL4
    wire [32:0]        msum   = {acc_in[31], acc_in} + {mq[31], mq};
    wire               m_ovf  = msum[32] ^ msum[31];

    // Load reorder: src_a holds elements in memory order, element zero in the low bits.
    reg  [DW-1:0] ld;
    always @* begin
        ld = src_a;
        if (!little_endian) begin // RL14
            case (lane_format)
                `FMT_QUAD: ld = {src_a[7:0], src_a[15:8], src_a[23:16], src_a[31:24]}; // RL13
                `FMT_PAIR: ld = {src_a[15:0], src_a[31:16]}; // RL13
                default: ld = src_a;
            endcase
        end
    end

    reg [DW-1:0] res_nxt;
    reg [FW-1:0] set_nxt;
    always @* begin
        res_nxt = {DW{1'b0}};
        set_nxt = {FW{1'b0}};
        case (op_code)
            `OP_ADD, `OP_SUB, `OP_SHL, `OP_MULQ: begin
                case (lane_format) // RL12
                    `FMT_QUAD: begin
                        res_nxt = y_quad;
                        set_nxt[`FLAG_ADDSUB] = (op_code == `OP_ADD || op_code == `OP_SUB)
                                                && (|o_quad); // RL16
                        set_nxt[`FLAG_SHIFT]  = (op_code == `OP_SHL) && (|o_quad);
                        set_nxt[`FLAG_MUL]    = (op_code == `OP_MULQ) && (|o_quad);
                    end
                    `FMT_PAIR: begin
                        res_nxt = y_pair; // RL10
                        set_nxt[`FLAG_ADDSUB] = (op_code == `OP_ADD || op_code == `OP_SUB)
                                                && (|o_pair); // RL16
                        set_nxt[`FLAG_SHIFT]  = (op_code == `OP_SHL) && (|o_pair);
                        set_nxt[`FLAG_MUL]    = (op_code == `OP_MULQ) && (|o_pair);
                    end
                    default: begin
                        res_nxt = y_w;
                        set_nxt[`FLAG_ADDSUB] = (op_code == `OP_ADD || op_code == `OP_SUB)
                                                && o_w; // RL16
                        set_nxt[`FLAG_SHIFT]  = (op_code == `OP_SHL) && o_w;
                        set_nxt[`FLAG_MUL]    = (op_code == `OP_MULQ) && o_w;
                    end
                endcase
            end
            `OP_PREC: begin
                // Halfword output from word input: source a goes left, source b right.
                res_nxt = {ha, hb}; // RL11
                set_nxt[`FLAG_SHIFT] = round_and_saturate_modifier & (ra_ovf | rb_ovf);
            end
            `OP_MAC: begin
                if (m_ovf && accumulate_saturate_modifier) begin // RL6
                    res_nxt = msum[32] ? `Q31_MIN : `Q31_MAX;
                end else begin
                    res_nxt = msum[31:0];
                end
                set_nxt[`FLAG_ACC0] = m_ovf | m_both;
            end
            `OP_LOAD: res_nxt = ld;
            default: res_nxt = {DW{1'b0}};
        endcase
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            result_r       <= {DW{1'b0}};
            result_valid_r <= 1'b0;
            ouflag_r       <= {FW{1'b0}};
        end else begin
            result_valid_r <= op_valid;
            if (op_valid) begin
                result_r <= res_nxt;
            end
            // A flag raised in the same cycle as a software write survives the write.
            if (flag_write) begin // RL17
                ouflag_r <= flag_wdata | (op_valid ? set_nxt : {FW{1'b0}});
            end else if (op_valid) begin
                ouflag_r <= ouflag_r | set_nxt; // RL16
            end
        end
    end
endmodule // fixed_point_simd_saturation

// ### design/simd_lane.v
// One packed lane: add, subtract, shift left and fractional multiply with saturation.
`timescale 1ns/1ps
`include "fixed_point_simd_defines.vh"

module simd_lane #(
    parameter W = 8
) (
    input  wire [W-1:0] a,
    input  wire [W-1:0] b,
    input  wire [2:0]   op,
    input  wire         is_signed,
    input  wire         sat,
    input  wire         rnd,
    input  wire [4:0]   shamt,
    output reg  [W-1:0] y,
    output reg          ovf
);
    localparam SW = $clog2(W);

    wire [W:0]            ea     = {is_signed & a[W-1], a};
    wire [W:0]            eb     = {is_signed & b[W-1], b};
    wire [W:0]            sum    = (op == `OP_SUB) ? ea - eb : ea + eb;
    wire [W-1:0]          maxv   = is_signed ? {1'b0, {(W-1){1'b1}}} : {W{1'b1}};
    wire [W-1:0]          minv   = is_signed ? {1'b1, {(W-1){1'b0}}} : {W{1'b0}};
    wire [2*W-1:0]        ext    = {{W{is_signed & a[W-1]}}, a};
    wire [2*W-1:0]        shv    = ext << shamt[SW-1:0];
    wire signed [2*W-1:0] prod   = $signed(a) * $signed(b);
    wire [2*W-1:0]        rconst = {{W{1'b0}}, rnd, {(W-1){1'b0}}};
    wire [2*W-1:0]        prq    = (prod << 1) + rconst;
    wire                  both_m = (a == {1'b1, {(W-1){1'b0}}}) && (b == {1'b1, {(W-1){1'b0}}});
    // Carry stops at the lane edge because every lane has its own W+1 bit adder.
    wire                  as_ovf = is_signed ? (sum[W] ^ sum[W-1]) : sum[W];
    wire                  as_neg = is_signed ? sum[W] : (op == `OP_SUB);
    wire                  sh_ovf = is_signed ? (shv[2*W-1:W-1] != {(W+1){a[W-1]}})
                                             : (shv[2*W-1:W] != {W{1'b0}});

    always @* begin
        y   = {W{1'b0}};
        ovf = 1'b0;
        case (op)
            `OP_ADD, `OP_SUB: begin
                ovf = as_ovf; // RL7
                if (as_ovf && sat) begin // RL1
                    y = as_neg ? minv : maxv; // RL2 RL3
                end else begin
                    y = sum[W-1:0]; // RL18 RL8
                end
            end
            `OP_SHL: begin
                ovf = sh_ovf;
                if (sh_ovf && sat) begin // RL1
                    y = (is_signed & a[W-1]) ? minv : maxv; // RL2 RL3
                end else begin
                    y = shv[W-1:0]; // RL18
                end
            end
            `OP_MULQ: begin
                ovf = both_m;
                // Minus one squared has no fractional code, so it clamps whatever the width.
                y = both_m ? {1'b0, {(W-1){1'b1}}} : prq[2*W-1:W]; // RL4 RL5
            end
            default: begin
                y   = {W{1'b0}};
                ovf = 1'b0;
            end
        endcase
    end
endmodule // simd_lane

// ### include/fixed_point_simd_defines.vh
// Opcodes, lane formats, flag positions and limits for the packed fixed-point datapath.
`ifndef FIXED_POINT_SIMD_DEFINES_VH
`define FIXED_POINT_SIMD_DEFINES_VH

`define OP_ADD        3'h0
`define OP_SUB        3'h1
`define OP_SHL        3'h2
`define OP_MULQ       3'h3
`define OP_PREC       3'h4
`define OP_MAC        3'h5
`define OP_LOAD       3'h6

`define FMT_WORD      2'h0
`define FMT_PAIR      2'h1
`define FMT_QUAD      2'h2

`define FLAG_ACC0     0
`define FLAG_ADDSUB   4
`define FLAG_MUL      5
`define FLAG_SHIFT    6

`define Q31_MAX       32'h7fffffff
`define Q31_MIN       32'h80000000
`define Q15_MAX       16'h7fff
`define Q15_MIN       16'h8000
`define HALF_ROUND    33'h000008000

`endif

// ### test/fixed_point_simd_saturation_sva.sv
// Assertion checker for the packed fixed-point datapath ports.
`timescale 1ns/1ps
`include "fixed_point_simd_defines.vh"
module simd_sat_checker #(
    parameter DW = 32,
    parameter FW = 8
) (
    input wire          mclk,
    input wire          reset,
    input wire          op_valid,
    input wire [2:0]    op_code,
    input wire [1:0]    lane_format,
    input wire          is_signed,
    input wire          saturate,
    input wire          round_and_saturate_modifier,
    input wire          little_endian,
    input wire [DW-1:0] src_a,
    input wire [DW-1:0] src_b,
    input wire          flag_write,
    input wire [FW-1:0] flag_wdata,
    input wire [DW-1:0] result_r,
    input wire          result_valid_r,
    input wire [FW-1:0] ouflag_r
);
    wire [DW:0]   s_sum = {src_a[DW-1], src_a} + {src_b[DW-1], src_b};
    wire          s_ovf = s_sum[DW] != s_sum[DW-1];
    wire [DW-1:0] s_exp = s_ovf ? (s_sum[DW] ? `Q31_MIN : `Q31_MAX) : s_sum[DW-1:0];
    wire [DW-1:0] q_exp = {src_a[31:24] + src_b[31:24], src_a[23:16] + src_b[23:16],
                           src_a[15:8] + src_b[15:8], src_a[7:0] + src_b[7:0]};
    wire [DW-1:0] rev   = {src_a[7:0], src_a[15:8], src_a[23:16], src_a[31:24]};
    wire          add_op = op_valid && op_code == `OP_ADD;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // The word add is only checked with the saturate bit set, though the rounding flag also saturates.
    sequence s_word_sat_add;
        add_op && saturate && lane_format == `FMT_WORD;
    endsequence
    sequence s_neg_one_sq;
        op_valid && op_code == `OP_MULQ && lane_format == `FMT_WORD && src_a == `Q31_MIN
            && src_b == `Q31_MIN;
    endsequence

    property p_answer; op_valid |=> result_valid_r; endproperty
    a_answer: assert property (p_answer) else $error("result missing");
    property p_idle; !op_valid |=> !result_valid_r && $stable(result_r); endproperty
    a_idle: assert property (p_idle) else $error("idle cycle changed result");
    property p_ssat; s_word_sat_add ##0 is_signed |=> result_r == $past(s_exp)
        && (ouflag_r[`FLAG_ADDSUB] || !$past(s_ovf)); endproperty
    a_ssat: assert property (p_ssat) else $error("signed word saturation wrong");
    property p_qwrap; add_op && lane_format == `FMT_QUAD && !saturate
        && !round_and_saturate_modifier |=> result_r == $past(q_exp); endproperty
    a_qwrap: assert property (p_qwrap) else $error("byte lanes not wrapped");
    property p_mulq; s_neg_one_sq |=> result_r == `Q31_MAX; endproperty
    a_mulq: assert property (p_mulq) else $error("minus one squared not clamped");
    property p_load_be; op_valid && op_code == `OP_LOAD && lane_format == `FMT_QUAD
        && !little_endian |=> result_r == $past(rev); endproperty
    a_load_be: assert property (p_load_be) else $error("big-endian order wrong");
    property p_sticky; !flag_write |=> (ouflag_r & $past(ouflag_r)) == $past(ouflag_r);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag cleared by itself");
    property p_fw; flag_write && !op_valid |=> ouflag_r == $past(flag_wdata); endproperty
    a_fw: assert property (p_fw) else $error("flag write lost");
endmodule // simd_sat_checker

bind fixed_point_simd_saturation simd_sat_checker #(.DW(DW), .FW(FW)) sva (.*);

// ### test/test_fixed_point_simd_saturation.sv
// Self-checking bench for the packed fixed-point datapath.
`timescale 1ns/1ps
`include "fixed_point_simd_defines.vh"
module test_fixed_point_simd_saturation;
    typedef struct packed {
        logic [2:0]  op;
        logic [1:0]  fmt;
        logic [5:0]  md;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] y;
        logic [31:0] c;
        logic [4:0]  s;
    } row_t;
    row_t       rows[$];
    row_t       cur = '0;
    logic       mclk = 1'b0;
    logic       reset = 1'b1;
    logic       op_valid = 1'b0;
    logic       flag_write = 1'b0;
    logic [7:0] flag_wdata = 8'h00;
    wire [31:0] result_r;
    wire        result_valid_r;
    wire [7:0]  ouflag_r;
    int         fails = 0;
    int         checks_done = 0;

    always #4 mclk = ~mclk;

    // Modifier bits of a row: signed, saturate, round, accumulate-saturate, left, little-endian.
    fixed_point_simd_saturation dut (.mclk(mclk), .reset(reset), .op_valid(op_valid),
        .op_code(cur.op), .lane_format(cur.fmt), .is_signed(cur.md[5]), .saturate(cur.md[4]),
        .round_and_saturate_modifier(cur.md[3]), .accumulate_saturate_modifier(cur.md[2]),
        .select_left(cur.md[1]), .little_endian(cur.md[0]), .shift_amount(cur.s),
        .src_a(cur.a), .src_b(cur.b), .acc_in(cur.c), .flag_write(flag_write),
        .flag_wdata(flag_wdata), .result_r(result_r), .result_valid_r(result_valid_r),
        .ouflag_r(ouflag_r));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic row(input logic [2:0] o, input logic [1:0] f, input logic [5:0] m,
        input logic [31:0] a, input logic [31:0] b, input logic [31:0] y,
        input logic [31:0] c = 32'h0, input logic [4:0] s = 5'h0);
        rows.push_back({o, f, m, a, b, y, c, s});
    endtask
    task automatic issue(input row_t r);
        @(posedge mclk);
        cur <= r;
        op_valid <= 1'b1;
        @(posedge mclk);
        op_valid <= 1'b0;
        #1;
        chk(result_valid_r, 1'b1);
        chk(result_r, r.y);
    endtask

    initial begin
        #5000;
        fails++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        row(`OP_ADD, `FMT_QUAD, 6'h30, 32'h7f000000, 32'h01000000, 32'h7f000000);
        row(`OP_SUB, `FMT_QUAD, 6'h10, 32'h01000030, 32'h02000010, 32'h00000020);
        row(`OP_SUB, `FMT_PAIR, 6'h30, 32'h80000005, 32'h00010003, 32'h80000002);
        row(`OP_ADD, `FMT_PAIR, 6'h20, 32'h7fffffff, 32'h00010001, 32'h80000000);
        row(`OP_ADD, `FMT_QUAD, 6'h00, 32'hff7f0180, 32'h01810180, 32'h00000200);
        row(`OP_ADD, `FMT_WORD, 6'h30, 32'h7fffffff, 32'h00000001, 32'h7fffffff);
        row(`OP_ADD, `FMT_WORD, 6'h10, 32'hffffffff, 32'h00000001, 32'hffffffff);
        row(`OP_MULQ, `FMT_WORD, 6'h30, 32'h80000000, 32'h80000000, 32'h7fffffff);
        row(`OP_MULQ, `FMT_PAIR, 6'h38, 32'h80000001, 32'h80004000, 32'h7fff0001);
        row(`OP_PREC, `FMT_PAIR, 6'h38, 32'h12348000, 32'h7fff8000, 32'h12357fff);
        row(`OP_SHL, `FMT_QUAD, 6'h30, 32'h40010000, 32'h0, 32'h7f020000, 32'h0, 5'h1);
        row(`OP_LOAD, `FMT_QUAD, 6'h00, 32'h03020100, 32'h0, 32'h00010203);
        row(`OP_LOAD, `FMT_PAIR, 6'h00, 32'h11112222, 32'h0, 32'h22221111);
        row(`OP_LOAD, `FMT_QUAD, 6'h01, 32'h03020100, 32'h0, 32'h03020100);
        row(`OP_MAC, `FMT_PAIR, 6'h26, 32'h40000000, 32'h40000000, 32'h20000000);
        row(`OP_MAC, `FMT_PAIR, 6'h24, 32'h8000, 32'h8000, 32'h7fffffff, 32'h70000000);
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        #1;
        chk(ouflag_r, 8'h00);
        foreach (rows[i]) begin
            issue(rows[i]);
        end
        $display("table test done");
        // The table overflows add, multiply, shift, reduce and accumulate, so bits 0, 4, 5, 6.
        chk(ouflag_r, 8'h71);
        @(posedge mclk);
        flag_write <= 1'b1;
        @(posedge mclk);
        flag_write <= 1'b0;
        #1 chk(ouflag_r, 8'h00);
        issue(rows[3]);
        chk(ouflag_r, 8'h10);
        $display("sticky flag test done");
        // Two operations back to back must each give their own answer on their own cycle.
        @(posedge mclk);
        cur <= rows[0];
        op_valid <= 1'b1;
        @(posedge mclk);
        cur <= rows[1];
        #1 chk(result_r, rows[0].y);
        @(posedge mclk);
        op_valid <= 1'b0;
        #1 chk(result_r, rows[1].y);
        @(posedge mclk);
        #1 chk(result_valid_r, 1'b0);
        chk(result_r, rows[1].y);
        $display("back to back test done");
        @(posedge mclk);
        reset <= 1'b1;
        #1 chk(ouflag_r, 8'h00);
        chk(result_r, 32'h0);
        @(posedge mclk);
        reset <= 1'b0;
        $display("reset test done");
        end_of_test();
    end
endmodule // test_fixed_point_simd_saturation
